// file: design/dfr_defines.vh
// Purpose: shared constants of the frequency reference / ramp block
// Assumes: frequency in 0.01 Hz, percent in 0.1 %, time in 0.1 s
// Notes: definitions only, no logic
`ifndef DFR_DEFINES_VH
`define DFR_DEFINES_VH

// ==========================================================
// terminal function codes
`define DFR_FN_JOG_FWD 8'h06
`define DFR_FN_JOG_REV 8'h07
`define DFR_FN_RSEL1 8'h0a
`define DFR_FN_ESTOP 8'h0e
`define DFR_FN_BBLOCK 8'h0f
`define DFR_FN_RSEL2 8'h1e

// ==========================================================
// scaling
`define DFR_FREQ_CEIL 16'h9c40
`define DFR_PCT_DIV 27'h00003e8
`define DFR_ADC_MAX 12'hfff
`define DFR_ADC_SHIFT 12

// ==========================================================
// mode settings
`define DFR_MINMODE_HOLD 1'b1
`define DFR_FLOOR_ZERO 1'b1
`define DFR_POL_INVERT 1'b1
`define DFR_AUX_AS_FREQ 8'h00
`define DFR_SRC_KEYPAD 2'h0
`define DFR_SRC_AIN1 2'h1
`define DFR_SRC_AIN2 2'h2

// ==========================================================
// defaults and timing
`define DFR_SIZE_SMALL 2'h0
`define DFR_SIZE_MEDIUM 2'h1
`define DFR_DEF_T_SMALL 16'h0064
`define DFR_DEF_T_MEDIUM 16'h0096
`define DFR_DEF_T_LARGE 16'h00c8
`define DFR_JOG_DEFAULT 16'h0258
`define DFR_TENTH_S_NS 100000000
`define DFR_CLK_PERIOD_NS 100

`endif

// file: design/dfr_top.v
// Purpose: frequency reference limits, ramp pair select, jog,
//          emergency stop, base block and ramp generator
// Assumes: all inputs synchronous to sys_clk_i, settings static
// Notes: one ramp step of 0.01 Hz at most per clock; a zero ramp time jumps, base block cuts to 0 Hz
`timescale 1ns/100ps
`default_nettype none
`include "dfr_defines.vh"

// What this block does
// - below minimum in warn mode raises warning
// - below minimum in hold mode runs minimum
// - sleep floor: lower limit or 0 Hz
// - clamp to upper limit percent of fmax
// - clamp to lower limit percent of fmax
// - start ramps to lower limit, at least minimum
// - upper below lower flags range error
// - limits apply to every reference source
// - frequency ceiling never above 400 Hz
// - ramp times span zero to full fmax
// - default ramp time follows drive size
// - two select inputs pick ramp pair
// - switch-over frequency picks pair one or four
// - digital pair select overrides switch-over
// - jog ramp times span full fmax
// - terminal jog runs at jog frequency
// - emergency stop decelerates and shows indication
// - base block cuts output, motor coasts
// - analog polarity normal or inverted
// - aux analog used only in aux mode
module dfr_top #(
    parameter [35:0] CYC_PER_TENTH = `DFR_TENTH_S_NS / `DFR_CLK_PERIOD_NS
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [5:0] term_i,
    input wire [47:0] term_func_i,
    input wire term_run_sel_i,
    input wire run_cmd_i,
    input wire run_rev_i,
    input wire motor_sel_i,
    input wire [15:0] fmax1_i,
    input wire [15:0] fmax2_i,
    input wire [15:0] fmin1_i,
    input wire [15:0] fmin2_i,
    input wire [10:0] upper_pct_i,
    input wire [10:0] lower_pct_i,
    input wire min_freq_mode_i,
    input wire sleep_i,
    input wire sleep_floor_sel_i,
    input wire [1:0] ref_src_i,
    input wire [15:0] keypad_freq_i,
    input wire [11:0] analog_voltage_input_i,
    input wire [11:0] analog_aux_input_i,
    input wire analog_polarity_i,
    input wire [7:0] aux_mode_i,
    input wire [15:0] accel_time_first_i,
    input wire [15:0] decel_time_first_i,
    input wire [15:0] accel_time_second_i,
    input wire [15:0] decel_time_second_i,
    input wire [15:0] accel_time_third_i,
    input wire [15:0] decel_time_third_i,
    input wire [15:0] accel_time_fourth_i,
    input wire [15:0] decel_time_fourth_i,
    input wire [15:0] switch_freq_i,
    input wire [15:0] jog_freq_i,
    input wire [15:0] jog_accel_time_i,
    input wire [15:0] jog_decel_time_i,
    input wire [15:0] estop_time_i,
    input wire [1:0] size_class_i,
    output wire [15:0] out_freq_o,
    output wire out_rev_o,
    output wire out_enable_o,
    output wire below_min_freq_warning_o,
    output wire limit_range_error_o,
    output wire emergency_stop_indication_o,
    output wire [1:0] ramp_pair_o,
    output wire jog_active_o,
    output wire [15:0] default_ramp_time_o,
    output wire [15:0] default_jog_freq_o
);

// ==========================================================
// states, one-hot
localparam [3:0] ST_IDLE = 4'h1; // output off, waiting
localparam [3:0] ST_RUN = 4'h2; // normal or jog run
localparam [3:0] ST_ESTOP = 4'h4; // emergency ramp down
localparam [3:0] ST_COAST = 4'h8; // output cut

// ==========================================================
// terminal function decode
wire [5:0] asg_jf, asg_jr, asg_rs1, asg_rs2, asg_es, asg_bb;
genvar gi;
generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_term
        // compare each terminal's assigned code
        assign asg_jf[gi] = term_func_i[8*gi+:8] == `DFR_FN_JOG_FWD;
        assign asg_jr[gi] = term_func_i[8*gi+:8] == `DFR_FN_JOG_REV;
        assign asg_rs1[gi] = term_func_i[8*gi+:8] == `DFR_FN_RSEL1;
        assign asg_rs2[gi] = term_func_i[8*gi+:8] == `DFR_FN_RSEL2;
        assign asg_es[gi] = term_func_i[8*gi+:8] == `DFR_FN_ESTOP;
        assign asg_bb[gi] = term_func_i[8*gi+:8] == `DFR_FN_BBLOCK;
    end
endgenerate

wire jog_fwd = |(asg_jf & term_i); // forward jog request
wire jog_rev = |(asg_jr & term_i); // reverse jog request
wire rsel1 = |(asg_rs1 & term_i); // ramp select bit 0
wire rsel2 = |(asg_rs2 & term_i); // ramp select bit 1
wire estop_in = |(asg_es & term_i); // emergency stop request
wire bblock_in = |(asg_bb & term_i); // base block request
// jog only honoured under terminal run control
wire jog_req = term_run_sel_i & (jog_fwd | jog_rev);

// ==========================================================
// motor selection and limits
wire [15:0] fmax_raw = motor_sel_i ? fmax2_i : fmax1_i;
wire [15:0] fmin = motor_sel_i ? fmin2_i : fmin1_i;
// fmax above the ceiling would let every derived limit pass it
wire [15:0] fmax = (fmax_raw > `DFR_FREQ_CEIL) ?
    `DFR_FREQ_CEIL : fmax_raw;

wire [26:0] up_prod = fmax * upper_pct_i;
wire [26:0] lo_prod = fmax * lower_pct_i;
wire [26:0] up_q = up_prod / `DFR_PCT_DIV;
wire [26:0] lo_q = lo_prod / `DFR_PCT_DIV;
// 109 % of fmax can pass 400 Hz, so cap both limits
wire [15:0] upper_f = (up_q > {11'h000, `DFR_FREQ_CEIL}) ?
    `DFR_FREQ_CEIL : up_q[15:0];
wire [15:0] lower_f = (lo_q > {11'h000, `DFR_FREQ_CEIL}) ?
    `DFR_FREQ_CEIL : lo_q[15:0];
wire range_err = upper_pct_i < lower_pct_i;

// ==========================================================
// analog scaling
wire ana_inv = analog_polarity_i == `DFR_POL_INVERT;
wire [11:0] a1 = ana_inv ?
    (`DFR_ADC_MAX - analog_voltage_input_i) :
    analog_voltage_input_i;
wire [11:0] a2 = ana_inv ?
    (`DFR_ADC_MAX - analog_aux_input_i) :
    analog_aux_input_i;
// stretch 0..4095 onto 0..4096 so full scale is exactly fmax
wire [12:0] a1s = {1'b0, a1} + {12'h000, a1[11]};
wire [12:0] a2s = {1'b0, a2} + {12'h000, a2[11]};
wire [28:0] a1p = fmax * a1s;
wire [28:0] a2p = fmax * a2s;
wire [15:0] ana1_f = a1p[`DFR_ADC_SHIFT+15:`DFR_ADC_SHIFT];
wire [15:0] ana2_f = (aux_mode_i == `DFR_AUX_AS_FREQ) ?
    a2p[`DFR_ADC_SHIFT+15:`DFR_ADC_SHIFT] : 16'h0000;

// ==========================================================
// reference select, clamp and minimum handling
reg [15:0] ref_raw; // selected reference
always @* begin
    case (ref_src_i)
        `DFR_SRC_AIN1: ref_raw = ana1_f;
        `DFR_SRC_AIN2: ref_raw = ana2_f;
        default: ref_raw = keypad_freq_i;
    endcase
end

// one clamp serves every source, jog included
function [15:0] dfr_clamp;
    input [15:0] f;
    input [15:0] hi;
    input [15:0] lo;
    begin
        if (f > hi) begin
            dfr_clamp = hi;
        end else if (f < lo) begin
            dfr_clamp = lo;
        end else begin
            dfr_clamp = f;
        end
    end
endfunction

wire [15:0] ref_c = dfr_clamp(ref_raw, upper_f, lower_f);
wire [15:0] jog_c = dfr_clamp(jog_freq_i, upper_f, lower_f);
wire below_min = ref_c < fmin;
wire hold_min = min_freq_mode_i == `DFR_MINMODE_HOLD;
// a nonzero lower limit must still respect the motor minimum
wire lift_min = below_min &
    (hold_min | (lower_pct_i != 11'h000));
wire [15:0] run_f = lift_min ? fmin : ref_c;
// sleeping pins the loop output at its floor
wire [15:0] sleep_f = (sleep_floor_sel_i == `DFR_FLOOR_ZERO) ?
    16'h0000 : lower_f;
wire [15:0] norm_f = sleep_i ? sleep_f : run_f;

// ==========================================================
// ramp pair select
wire dig_sel = |(asg_rs1 | asg_rs2); // any select input assigned
wire [1:0] auto_pair = ((switch_freq_i != 16'h0000) &&
    (out_freq_o >= switch_freq_i)) ? 2'h3 : 2'h0;
wire [1:0] pair = dig_sel ? {rsel2, rsel1} : auto_pair;
reg [15:0] acc_t; // selected accel time
reg [15:0] dec_t; // selected decel time
always @* begin
    case (pair)
        2'h1: begin
            acc_t = accel_time_second_i;
            dec_t = decel_time_second_i;
        end
        2'h2: begin
            acc_t = accel_time_third_i;
            dec_t = decel_time_third_i;
        end
        2'h3: begin
            acc_t = accel_time_fourth_i;
            dec_t = decel_time_fourth_i;
        end
        default: begin
            acc_t = accel_time_first_i;
            dec_t = decel_time_first_i;
        end
    endcase
end

// ==========================================================
// state and ramp registers
reg [3:0] state_r, state_nxt;
reg [15:0] out_freq_r, out_freq_nxt;
reg [35:0] acc_r, acc_nxt; // ramp step accumulator
reg rev_r, rev_nxt;
reg jog_r, jog_nxt;
reg en_r, en_nxt;
reg warn_r, err_r, esi_r;
reg [1:0] pair_r;
reg [15:0] def_t_r, def_jog_r;

wire want_rev = jog_r ? jog_rev : run_rev_i;
wire run_req = jog_r ? jog_req : run_cmd_i;

// ==========================================================
// target and ramp time for the current state
reg [15:0] tgt; // frequency being ramped to
reg [15:0] t_up; // accel time in use
reg [15:0] t_dn; // decel time in use
always @* begin
    tgt = 16'h0000;
    t_up = jog_r ? jog_accel_time_i : acc_t;
    t_dn = jog_r ? jog_decel_time_i : dec_t;
    case (state_r)
        ST_RUN: begin
            // reversal goes through zero first
            if (run_req && (want_rev == rev_r)) begin
                tgt = jog_r ? jog_c : norm_f;
            end
        end
        ST_ESTOP: begin
            t_dn = estop_time_i;
        end
        default: begin
            tgt = 16'h0000;
        end
    endcase
end

// ==========================================================
// linear ramp: add fmax per clock, step when a whole
// ramp time's worth of clocks has been covered
wire ramp_up = out_freq_r < tgt;
wire [35:0] den = (ramp_up ? t_up : t_dn) * CYC_PER_TENTH;
wire [36:0] acc_sum = {1'b0, acc_r} + {21'h000000, fmax};
wire [36:0] acc_left = acc_sum - {1'b0, den};
wire step = acc_sum >= {1'b0, den};
reg [15:0] ramp_f; // frequency after this clock's step
reg [35:0] ramp_acc; // accumulator after this clock
always @* begin
    ramp_f = out_freq_r;
    ramp_acc = 36'h000000000;
    if (out_freq_r == tgt) begin
        ramp_acc = 36'h000000000;
    end else if (den == 36'h000000000) begin
        ramp_f = tgt; // zero time: jump
    end else if (step) begin
        ramp_acc = acc_left[35:0];
        ramp_f = ramp_up ? out_freq_r + 16'h0001 :
            out_freq_r - 16'h0001;
    end else begin
        ramp_acc = acc_sum[35:0];
    end
end

// ==========================================================
// run sequencing
always @* begin
    state_nxt = state_r;
    out_freq_nxt = ramp_f;
    acc_nxt = ramp_acc;
    rev_nxt = rev_r;
    jog_nxt = jog_r;
    en_nxt = en_r;
    if (bblock_in) begin
        // no ramp: output is cut in the same clock
        state_nxt = ST_COAST;
        out_freq_nxt = 16'h0000;
        acc_nxt = 36'h000000000;
        en_nxt = 1'b0;
    end else begin
        case (state_r)
            ST_IDLE: begin
                out_freq_nxt = 16'h0000;
                acc_nxt = 36'h000000000;
                en_nxt = 1'b0;
                if (estop_in) begin
                    state_nxt = ST_ESTOP;
                end else if (run_cmd_i) begin
                    state_nxt = ST_RUN;
                    rev_nxt = run_rev_i;
                    jog_nxt = 1'b0;
                    en_nxt = 1'b1;
                end else if (jog_req) begin
                    state_nxt = ST_RUN;
                    rev_nxt = jog_rev;
                    jog_nxt = 1'b1;
                    en_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                if (estop_in) begin
                    state_nxt = ST_ESTOP;
                end else if (out_freq_r == 16'h0000) begin
                    if (!run_req) begin
                        state_nxt = ST_IDLE;
                        en_nxt = 1'b0;
                    end else if (want_rev != rev_r) begin
                        rev_nxt = want_rev;
                    end
                end
            end
            ST_ESTOP: begin
                if (out_freq_r == 16'h0000) begin
                    en_nxt = 1'b0;
                    // a held run command must not restart
                    if (!run_cmd_i && !jog_req && !estop_in) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_COAST: begin
                out_freq_nxt = 16'h0000;
                acc_nxt = 36'h000000000;
                en_nxt = 1'b0;
                // a stop input still held must not be lost here
                state_nxt = estop_in ? ST_ESTOP : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
                out_freq_nxt = 16'h0000;
                en_nxt = 1'b0;
            end
        endcase
    end
end

// ==========================================================
// state registers
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        state_r <= ST_IDLE;
        out_freq_r <= 16'h0000;
        acc_r <= 36'h000000000;
        rev_r <= 1'b0;
        jog_r <= 1'b0;
        en_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        out_freq_r <= out_freq_nxt;
        acc_r <= acc_nxt;
        rev_r <= rev_nxt;
        jog_r <= jog_nxt;
        en_r <= en_nxt;
    end
end

// ==========================================================
// status registers
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        warn_r <= 1'b0;
        err_r <= 1'b0;
        esi_r <= 1'b0;
        pair_r <= 2'h0;
        def_t_r <= `DFR_DEF_T_SMALL;
        def_jog_r <= `DFR_JOG_DEFAULT;
    end else begin
        warn_r <= below_min & ~hold_min;
        err_r <= range_err;
        esi_r <= state_nxt == ST_ESTOP;
        pair_r <= pair;
        def_jog_r <= `DFR_JOG_DEFAULT;
        case (size_class_i)
            `DFR_SIZE_SMALL: def_t_r <= `DFR_DEF_T_SMALL;
            `DFR_SIZE_MEDIUM: def_t_r <= `DFR_DEF_T_MEDIUM;
            default: def_t_r <= `DFR_DEF_T_LARGE;
        endcase
    end
end

assign out_freq_o = out_freq_r;
assign out_rev_o = rev_r;
assign out_enable_o = en_r;
assign below_min_freq_warning_o = warn_r;
assign limit_range_error_o = err_r;
assign emergency_stop_indication_o = esi_r;
assign ramp_pair_o = pair_r;
assign jog_active_o = jog_r;
assign default_ramp_time_o = def_t_r;
assign default_jog_freq_o = def_jog_r;

endmodule // dfr_top
`default_nettype wire

// file: verification/dfr_motor_model.sv
// Purpose: far side of the block, terminal contacts and a driven motor
// Assumes: contacts change on the clock, motor speed in 0.01 Hz
// Notes: motor follows the output while on and coasts slowly when off
`timescale 1ns/100ps
`default_nettype none
module dfr_motor_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [5:0] term_req_i,
    input wire logic [15:0] out_freq_i,
    input wire logic out_enable_i,
    output var logic [5:0] term_o,
    output var logic [15:0] speed_o
);
    // ==========================================================
    // contacts and rotor
    // one register stage, like an input card with filtering
    always_ff @(posedge sys_clk_i) begin
        term_o <= term_req_i;
        if (rst_i) begin
            speed_o <= 16'h0000;
        end else if (out_enable_i) begin
            speed_o <= out_freq_i;
        end else if (speed_o != 16'h0000) begin
            // inertia: loses 0.01 Hz per clock, as much as one output step
            speed_o <= speed_o - 16'h0001;
        end
    end
endmodule // dfr_motor_model
`default_nettype wire

// file: verification/dfr_chk_asserts.sv
// Purpose: port checks on the reference limit and ramp block
// Assumes: one clock, synchronous active-high reset
// Notes: bound into dfr_top below the module
`timescale 1ns/100ps
`default_nettype none
`include "dfr_defines.vh"
module dfr_chk #(
    parameter [35:0] CYC_PER_TENTH = 36'h00000000a
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [5:0] term_i,
    input wire [47:0] term_func_i,
    input wire motor_sel_i,
    input wire [15:0] fmax1_i,
    input wire [15:0] fmin1_i,
    input wire [10:0] upper_pct_i,
    input wire [10:0] lower_pct_i,
    input wire min_freq_mode_i,
    input wire sleep_i,
    input wire [1:0] ref_src_i,
    input wire [15:0] keypad_freq_i,
    input wire [15:0] switch_freq_i,
    input wire [15:0] out_freq_o,
    input wire out_enable_o,
    input wire below_min_freq_warning_o,
    input wire limit_range_error_o,
    input wire emergency_stop_indication_o,
    input wire [1:0] ramp_pair_o
);
    // ==========================================================
    // decoded terminal functions
    logic bb_act, es_act, sel1, sel2, dig_asg;
    logic [7:0] fc; // code of the terminal in hand
    always_comb begin
        fc = 8'h00;
        bb_act = 1'b0;
        es_act = 1'b0;
        sel1 = 1'b0;
        sel2 = 1'b0;
        dig_asg = 1'b0;
        for (int k = 0; k < 6; k++) begin
            fc = term_func_i[8*k +: 8];
            bb_act |= term_i[k] && fc == `DFR_FN_BBLOCK;
            es_act |= term_i[k] && fc == `DFR_FN_ESTOP;
            sel1 |= term_i[k] && fc == `DFR_FN_RSEL1;
            sel2 |= term_i[k] && fc == `DFR_FN_RSEL2;
            // an assigned but open selector still overrides auto pairing
            dig_asg |= fc == `DFR_FN_RSEL1 || fc == `DFR_FN_RSEL2;
        end
    end
    // ==========================================================
    // assertions; the reset edge is masked through past(rst_i)
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    range_flag_a: assert property (
        !$past(rst_i) |-> limit_range_error_o == $past(upper_pct_i < lower_pct_i))
        else $error("range flag wrong");
    base_block_a: assert property (
        !$past(rst_i) && $past(bb_act) |-> !out_enable_o && out_freq_o == 16'h0000)
        else $error("base block left output on");
    estop_flag_a: assert property (
        !$past(rst_i) && $past(es_act && !bb_act) |-> emergency_stop_indication_o)
        else $error("emergency indication missing");
    pair_select_a: assert property (
        !$past(rst_i) && $past(dig_asg) |-> ramp_pair_o == $past({sel2, sel1}))
        else $error("ramp pair not from selectors");
    pair_auto_a: assert property (
        !$past(rst_i) && $past(!dig_asg && switch_freq_i != 16'h0000)
        |-> ramp_pair_o == ($past(out_freq_o) >= $past(switch_freq_i) ? 2'h3 : 2'h0))
        else $error("switch-over pair wrong");
    ramp_step_a: assert property (
        !$past(rst_i) && !$past(bb_act) |-> out_freq_o <= $past(out_freq_o) + 17'h00001
        && $past(out_freq_o) <= out_freq_o + 17'h00001)
        else $error("output frequency jumped");
    freq_ceiling_a: assert property (
        out_freq_o <= `DFR_FREQ_CEIL) else $error("output above ceiling");
    below_min_a: assert property (
        !$past(rst_i) && $past(!min_freq_mode_i && !motor_sel_i && !sleep_i
        && ref_src_i == 2'h0 && keypad_freq_i < fmin1_i && fmin1_i <= fmax1_i
        && lower_pct_i == 11'h000 && upper_pct_i >= 11'h3e8)
        |-> below_min_freq_warning_o) else $error("below minimum not flagged");
endmodule // dfr_chk
bind dfr_top dfr_chk #(.CYC_PER_TENTH(CYC_PER_TENTH)) u_chk (.*);
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: directed bench for the reference limit and ramp block
// Assumes: 10 MHz clock, clocks per 0.1 s cut down to 100
// Notes: frequencies in 0.01 Hz, times in 0.1 s, one step per clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int CYC = 100; // clocks per tenth, shortened for run time
    // ==========================================================
    // stimulus, all given a value at time zero
    logic sys_clk_i = 1'b0, rst_i = 1'b1, run_cmd_i = 1'b0, run_rev_i = 1'b0;
    logic term_run_sel_i = 1'b0, motor_sel_i = 1'b0, sleep_i = 1'b0;
    logic min_freq_mode_i = 1'b0, sleep_floor_sel_i = 1'b0;
    logic analog_polarity_i = 1'b0;
    logic [5:0] term_req = 6'h00, term_i;
    logic [47:0] term_func_i = 48'h000000000000;
    logic [15:0] fmax1_i = 16'h1770, fmax2_i = 16'h0fa0, fmin1_i = 16'h012c;
    logic [15:0] fmin2_i = 16'h00c8, keypad_freq_i = 16'h0000;
    localparam logic [15:0] T = 16'h003c; // 6 s for every ramp time
    logic [15:0] switch_freq_i = 16'h0000, jog_freq_i = 16'h03e8;
    logic [15:0] jog_accel_time_i = T, jog_decel_time_i = T, estop_time_i = T;
    logic [15:0] accel_time_first_i = T, decel_time_first_i = T;
    logic [15:0] accel_time_second_i = T, decel_time_second_i = T;
    logic [15:0] accel_time_third_i = T, decel_time_third_i = T;
    logic [15:0] accel_time_fourth_i = T, decel_time_fourth_i = T;
    logic [10:0] upper_pct_i = 11'h3e8, lower_pct_i = 11'h000;
    logic [1:0] ref_src_i = 2'h0, size_class_i = 2'h0, ramp_pair_o;
    logic [11:0] analog_voltage_input_i = 12'h000, analog_aux_input_i = 12'h000;
    logic [7:0] aux_mode_i = 8'h01;
    logic [15:0] out_freq_o, default_ramp_time_o, default_jog_freq_o, spd;
    logic out_rev_o, out_enable_o, below_min_freq_warning_o, jog_active_o;
    logic limit_range_error_o, emergency_stop_indication_o;
    logic [15:0] def_t [4] = '{16'h0064, 16'h0096, 16'h00c8, 16'h00c8};
    int bad_count = 0, n_checks = 0, cnt;
    // ==========================================================
    // block and far side
    dfr_top #(.CYC_PER_TENTH(CYC)) u_dut (.*);
    dfr_motor_model u_motor (.sys_clk_i, .rst_i, .term_req_i(term_req),
        .out_freq_i(out_freq_o), .out_enable_i(out_enable_o), .term_o(term_i),
        .speed_o(spd));
    // free-running 100 ns clock
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
        // next stimulus then lands on a rising edge
        @(posedge sys_clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // outputs are read on the falling edge, well clear of updates
    task automatic look(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // bounded wait for the ramp to land; a timeout ends the run
    task automatic wait_f(input logic [15:0] e);
        cnt = 0;
        while (out_freq_o !== e && cnt < 60000) begin
            look(1);
            cnt++;
        end
        chk("out_freq_o", e, out_freq_o);
        if (cnt >= 60000) stop_test();
    endtask
    // code and contact of one terminal, one model stage of delay
    task automatic term_set(input int k, input logic [7:0] f, input logic l);
        @(posedge sys_clk_i);
        term_func_i[8*k +: 8] <= f;
        term_req[k] <= l;
        look(3);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        look(1);
        chk("def_jog", 16'h0258, default_jog_freq_o);
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk_i);
            size_class_i <= s[1:0];
            look(2);
            chk("def_ramp", def_t[s], default_ramp_time_o);
        end
        // limits on every source, sleep floor, second motor
        @(posedge sys_clk_i);
        {run_cmd_i, keypad_freq_i, upper_pct_i} <= {1'b1, 16'h1388, 11'h1f4};
        wait_f(16'h0bb8);
        {lower_pct_i, keypad_freq_i} <= {11'h0c8, 16'h0064};
        wait_f(16'h04b0);
        {ref_src_i, analog_voltage_input_i} <= {2'h1, 12'hfff};
        wait_f(16'h0bb8);
        analog_polarity_i <= 1'b1;
        wait_f(16'h04b0);
        {ref_src_i, analog_polarity_i, analog_aux_input_i} <= {2'h2, 13'h0fff};
        look(40);
        chk("aux_ignored", 16'h04b0, out_freq_o);
        aux_mode_i <= 8'h00;
        wait_f(16'h0bb8);
        sleep_i <= 1'b1;
        wait_f(16'h04b0);
        sleep_floor_sel_i <= 1'b1;
        wait_f(16'h0000);
        {sleep_i, ref_src_i, lower_pct_i} <= {1'b0, 2'h0, 11'h000};
        {motor_sel_i, keypad_freq_i} <= {1'b1, 16'h1388};
        wait_f(16'h07d0);
        motor_sel_i <= 1'b0;
        wait_f(16'h0bb8);
        $display("test limits done");
        // below-minimum warning and hold
        {run_cmd_i, upper_pct_i, keypad_freq_i} <= {1'b0, 11'h3e8, 16'h0064};
        wait_f(16'h0000);
        chk("warning", 16'h0001, below_min_freq_warning_o);
        {min_freq_mode_i, run_cmd_i} <= 2'h3;
        wait_f(16'h012c);
        chk("warning_hold", 16'h0000, below_min_freq_warning_o);
        {upper_pct_i, lower_pct_i} <= {11'h064, 11'h0c8};
        look(2);
        chk("range_error", 16'h0001, limit_range_error_o);
        {upper_pct_i, lower_pct_i} <= {11'h3e8, 11'h000};
        wait_f(16'h012c);
        chk("range_clear", 16'h0000, limit_range_error_o);
        $display("test minimum done");
        // ramp pairs by selectors, rate, then switch-over
        switch_freq_i <= 16'h07d0;
        term_set(1, 8'h1e, 1'b0);
        for (int v = 0; v < 4; v++) begin
            term_set(0, 8'h0a, v[0]);
            term_set(1, 8'h1e, v[1]);
            chk("ramp_pair_sel", 16'(v), ramp_pair_o);
        end
        {accel_time_fourth_i, keypad_freq_i} <= {16'h0078, 16'h0258};
        wait_f(16'h0258);
        chk("ramp_clocks", 16'h0258, (cnt > 594 && cnt < 606) ? 16'h0258 : 16'(cnt));
        term_set(0, 8'h00, 1'b0);
        term_set(1, 8'h00, 1'b0);
        chk("ramp_pair_low", 16'h0000, ramp_pair_o);
        keypad_freq_i <= 16'h0bb8;
        wait_f(16'h0bb8);
        chk("ramp_pair_high", 16'h0003, ramp_pair_o);
        switch_freq_i <= 16'h0000;
        $display("test pairs done");
        // terminal jog both ways
        {run_cmd_i, term_run_sel_i} <= 2'h1;
        wait_f(16'h0000);
        term_set(2, 8'h06, 1'b1);
        wait_f(16'h03e8);
        chk("jog_fwd", 16'h0001, {out_rev_o, jog_active_o});
        term_set(2, 8'h06, 1'b0);
        wait_f(16'h0000);
        term_set(2, 8'h07, 1'b1);
        wait_f(16'h03e8);
        chk("jog_rev", 16'h0003, {out_rev_o, jog_active_o});
        term_set(2, 8'h07, 1'b0);
        wait_f(16'h0000);
        $display("test jog done");
        // emergency stop, refused restart, start to lower limit
        {term_run_sel_i, run_cmd_i} <= 2'h1;
        wait_f(16'h0bb8);
        term_set(3, 8'h0e, 1'b1);
        chk("estop_ind", 16'h0001, emergency_stop_indication_o);
        wait_f(16'h0000);
        term_set(3, 8'h0e, 1'b0);
        look(20);
        chk("restart_refused", 16'h0000, {out_enable_o, out_freq_o[14:0]});
        run_cmd_i <= 1'b0;
        look(3);
        chk("estop_cleared", 16'h0000, emergency_stop_indication_o);
        {lower_pct_i, keypad_freq_i, run_cmd_i} <= {11'h0c8, 16'h0064, 1'b1};
        wait_f(16'h04b0);
        chk("enabled", 16'h0001, out_enable_o);
        $display("test estop done");
        // base block cuts output, rotor coasts
        term_set(4, 8'h0f, 1'b1);
        chk("bblock_out", 16'h0000, {out_enable_o, out_freq_o[14:0]});
        chk("coasting", 16'h0001, spd > 16'h044c);
        term_set(4, 8'h0f, 1'b0);
        $display("test base block done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
